/* File: design/pnf_consts.svh */
/*
 * Constants for the parallel flash host controller: register offsets,
 * command encodings, address patterns and timing figures.
 * Assumes a 100 MHz clock; counts are derived from the printed times.
 */
`ifndef PNF_CONSTS_SVH
`define PNF_CONSTS_SVH

`define PNF_CLK_MHZ 100
`define PNF_NS_PER_CYC 10

// Software register offsets
`define PNF_REG_CTRL 4'h0
`define PNF_REG_ADDR 4'h1
`define PNF_REG_WDATA 4'h2
`define PNF_REG_RDATA 4'h3
`define PNF_REG_STAT 4'h4

// Control register command codes (written to CTRL[3:0])
`define PNF_CMD_READ 4'h1
`define PNF_CMD_PROG 4'h2
`define PNF_CMD_RESET 4'h3
`define PNF_CMD_PROT 4'h4
`define PNF_CMD_UNPROT 4'h5
`define PNF_CMD_TEMPUN 4'h6
`define PNF_CMD_WRITE 4'h7
`define PNF_CMD_POLL 4'h8

// Control bits
`define PNF_CTRL_BYTE 4
`define PNF_CTRL_OESTROBE 5

// Program sequence
`define PNF_UNLOCK1_ADDR 20'h00555
`define PNF_UNLOCK1_DATA 16'h00aa
`define PNF_UNLOCK2_ADDR 20'h002aa
`define PNF_UNLOCK2_DATA 16'h0055
`define PNF_PROG_ADDR 20'h00555
`define PNF_PROG_DATA 16'h00a0

// Protect address bits
`define PNF_BIT_A6 6
`define PNF_BIT_A3 3
`define PNF_BIT_A2 2
`define PNF_BIT_A1 1
`define PNF_BIT_A0 0

// Status bit positions in read data
`define PNF_POLL_BIT 7
`define PNF_OPTOG_BIT 6
`define PNF_ERTOG_BIT 2

// Timing in ns, and cycle counts: least times round up
`define PNF_T_PULSE_NS 40
`define PNF_T_READ_NS 80
`define PNF_T_RH_NS 50
`define PNF_T_SRW_NS 20
`define PNF_T_RP_NS 500
`define PNF_T_READY_LONG_NS 35000
`define PNF_T_RSP_NS 4000
`define PNF_T_RRB_NS 4000
`define PNF_T_BUSY_NS 90
`define PNF_SYNC_CYC 2
`define PNF_CYC(ns) (((ns) + `PNF_NS_PER_CYC - 1) / `PNF_NS_PER_CYC)
`define PNF_CNT_W 12

`endif

/* File: design/pnf_pkg.sv */
/*
 * Types of the parallel flash host controller.
 * Assumes nothing beyond the constants header.
 */
package pnf_pkg;
    typedef enum logic [4:0] {
        PNF_IDLE,
        PNF_RST_LOW,
        PNF_RST_REC,
        PNF_W_SETUP,
        PNF_W_PULSE,
        PNF_W_HOLD,
        PNF_R_PULSE,
        PNF_R_GAP,
        PNF_BUSY_WAIT,
        PNF_TEMP_RISE,
        PNF_TEMP_HOLD,
        PNF_TEMP_OFF
    } pnf_state_t;
endpackage

/* File: design/pnf_sync.sv */
/*
 * Two flip-flop synchroniser for one level from a pin.
 * Assumes an asynchronous active-low reset; output idles at RST_VAL.
 */
`timescale 1ns/10ps
`default_nettype none
module pnf_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic pinIn,
    output logic syncOut
);
    logic stage1_reg;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stage1_reg <= RST_VAL;
            syncOut <= RST_VAL;
        end else begin
            stage1_reg <= pinIn;
            syncOut <= stage1_reg;
        end
    end
endmodule
`default_nettype wire

/* File: design/pnf_timer.sv */
/*
 * Down counter used for every bus timing wait except the long reset recovery.
 * Assumes load and count never coincide with a need for the old value.
 */
`timescale 1ns/10ps
`default_nettype none
`include "pnf_consts.svh"
module pnf_timer (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic load,
    input wire logic [`PNF_CNT_W-1:0] loadVal,
    output logic done
);
    logic [`PNF_CNT_W-1:0] count_reg;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count_reg <= '0;
        end else if (load) begin
            count_reg <= loadVal;
        end else if (count_reg != '0) begin
            count_reg <= count_reg - `PNF_CNT_W'(1);
        end
    end

    assign done = (count_reg == '0) && !load;
endmodule
`default_nettype wire

/* File: design/pnf_host.sv */
/*
 * Host controller for an asynchronous parallel NOR flash.
 * Software issues commands through a small register port; the controller
 * sequences chip select, output enable, write enable, reset (with an
 * elevated-level request for temporary unprotect) and the data bus.
 * Assumes the flash pins are asynchronous; readyBusyN and the data bus
 * inputs are synchronised before use.
 */
//
// Overview of operation
// RL1: Program ends with A0h written to 555h, then data to target address.
// RL2: Status read at program address until true data returns; device duty.
// RL3: Reset during an algorithm: device ready within 35 us; host waits that.
// RL4: Reset while idle: device ready within 500 ns.
// RL5: After reset released, wait at least 50 ns before any read.
// RL6: Reset held low brings device to standby within 35 us; device duty.
// RL7: Chip select asserted only after reset has gone high.
// RL8: Device drives busy within 90 ns of final write; host waits that long.
// RL9: New cycle may start with no delay once ready is seen.
// RL10: Leave at least 20 ns between read end and write start.
// RL11: Erase toggle bit toggles only inside an erase-suspended sector.
// RL12: Each status read is a toggle event; either strobe may make it.
// RL13: Protect cycle address: bit6=0, bits3,2=0, bit1=1, bit0=0.
// RL14: Unprotect cycle address: bit6=1, bits3,2=0, bit1=1, bit0=0.
// RL15: Hold elevated reset 4 us before the first write of temp unprotect.
// RL16: Keep reset elevated 4 us after ready returns in temp unprotect.
// RL17: In byte mode device floats upper data within 16 ns.
// RL18: Poll bit reads complement of written data bit while programming.
// RL19: Erase preprograms the sector to zero; device duty.
// RL20: Device sleeps when addresses stay stable; device duty.
// RL21: Program and erase durations keep ready/busy busy throughout.
`timescale 1ns/10ps
`default_nettype none
`include "pnf_consts.svh"
module pnf_host #(
    parameter int READY_LONG_CYC = `PNF_CYC(`PNF_T_READY_LONG_NS)
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    output logic [19:0] flashAddr,
    output logic [15:0] flashDqOut,
    output logic flashDqOe,
    input wire logic [15:0] flashDqIn,
    output logic flashCeN,
    output logic flashOeN,
    output logic flashWeN,
    output logic flashResetN,
    output logic flashResetHv,
    output logic flashByteN,
    input wire logic ready_busy_n
);
    localparam logic [`PNF_CNT_W-1:0] PULSE_CYC = `PNF_CNT_W'(`PNF_CYC(`PNF_T_PULSE_NS));
    localparam logic [`PNF_CNT_W-1:0] READ_CYC = `PNF_CNT_W'(`PNF_CYC(`PNF_T_READ_NS));
    localparam logic [`PNF_CNT_W-1:0] RH_CYC = `PNF_CNT_W'(`PNF_CYC(`PNF_T_RH_NS));
    localparam logic [`PNF_CNT_W-1:0] SRW_CYC = `PNF_CNT_W'(`PNF_CYC(`PNF_T_SRW_NS));
    localparam logic [`PNF_CNT_W-1:0] RP_CYC = `PNF_CNT_W'(`PNF_CYC(`PNF_T_RP_NS));
    localparam logic [`PNF_CNT_W-1:0] RSP_CYC = `PNF_CNT_W'(`PNF_CYC(`PNF_T_RSP_NS));
    localparam logic [`PNF_CNT_W-1:0] RRB_CYC = `PNF_CNT_W'(`PNF_CYC(`PNF_T_RRB_NS));
    // Covers the busy-assert delay plus synchroniser latency
    localparam logic [`PNF_CNT_W-1:0] BUSY_CYC = `PNF_CNT_W'(`PNF_CYC(`PNF_T_BUSY_NS) + `PNF_SYNC_CYC);
    localparam int LONG_W = $clog2(READY_LONG_CYC + 1) + 1;

    pnf_pkg::pnf_state_t state_reg;
    logic [3:0] cmd_reg;
    logic [1:0] step_reg;
    logic byteMode_reg;
    logic oeStrobe_reg;
    logic [19:0] addr_reg;
    logic [15:0] wdata_reg;
    logic [15:0] rdata_reg;
    logic opDone_reg;
    logic toggled_reg;
    logic [15:0] lastStat_reg;
    logic algoActive_reg;
    logic tempMode_reg;
    logic [LONG_W-1:0] longCnt_reg;
    logic timerLoad;
    logic [`PNF_CNT_W-1:0] timerVal;
    logic timerDone;
    logic readySync;
    logic [15:0] dqSync;
    logic busy;
    logic startCmd;

    pnf_sync #(.RST_VAL(1'b1)) u_rdy_sync (
        .clk(clk),
        .rst_b(rst_b),
        .pinIn(ready_busy_n),
        .syncOut(readySync)
    );

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_dq_sync
            pnf_sync #(.RST_VAL(1'b0)) u_dq (
                .clk(clk),
                .rst_b(rst_b),
                .pinIn(flashDqIn[gi]),
                .syncOut(dqSync[gi])
            );
        end
    endgenerate

    pnf_timer u_timer (
        .clk(clk),
        .rst_b(rst_b),
        .load(timerLoad),
        .loadVal(timerVal),
        .done(timerDone)
    );

    // Address pattern for a protect or unprotect cycle
    function automatic logic [19:0] prot_addr(input logic [19:0] base, input logic unprot);
        logic [19:0] a;
        a = base;
        a[`PNF_BIT_A6] = unprot;
        a[`PNF_BIT_A3] = 1'b0;
        a[`PNF_BIT_A2] = 1'b0;
        a[`PNF_BIT_A1] = 1'b1;
        a[`PNF_BIT_A0] = 1'b0;
        return a;
    endfunction

    // Address and data driven on each write step of a command
    function automatic logic [35:0] write_step(input logic [3:0] cmd, input logic [1:0] step,
                                               input logic [19:0] a, input logic [15:0] d);
        logic [35:0] r;
        r = {a, d};
        if (cmd == `PNF_CMD_PROG) begin
            unique case (step)
                2'h0: r = {`PNF_UNLOCK1_ADDR, `PNF_UNLOCK1_DATA};
                2'h1: r = {`PNF_UNLOCK2_ADDR, `PNF_UNLOCK2_DATA};
                2'h2: r = {`PNF_PROG_ADDR, `PNF_PROG_DATA}; // RL1
                default: r = {a, d}; // RL1
            endcase
        end else if (cmd == `PNF_CMD_PROT) begin
            r = {prot_addr(a, 1'b0), d}; // RL13
        end else if (cmd == `PNF_CMD_UNPROT) begin
            r = {prot_addr(a, 1'b1), d}; // RL14
        end
        return r;
    endfunction

    function automatic logic [1:0] last_step(input logic [3:0] cmd);
        return (cmd == `PNF_CMD_PROG) ? 2'h3 : 2'h0;
    endfunction

    // Flash reset low counts as busy, so no command can pull chip select low under it
    assign busy = (state_reg != pnf_pkg::PNF_IDLE) || !flashResetN; // RL7
    assign startCmd = regWr && (regAddr == `PNF_REG_CTRL) && !busy;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            byteMode_reg <= 1'b0;
            oeStrobe_reg <= 1'b1;
            addr_reg <= '0;
            wdata_reg <= '0;
        end else if (regWr && !busy) begin
            unique case (regAddr)
                `PNF_REG_CTRL: begin
                    byteMode_reg <= regWdata[`PNF_CTRL_BYTE];
                    oeStrobe_reg <= regWdata[`PNF_CTRL_OESTROBE];
                end
                `PNF_REG_ADDR: addr_reg <= regWdata[19:0];
                `PNF_REG_WDATA: wdata_reg <= regWdata[15:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            regRdata <= '0;
        end else if (regRd) begin
            unique case (regAddr)
                `PNF_REG_CTRL: regRdata <= {26'h0, oeStrobe_reg, byteMode_reg, cmd_reg};
                `PNF_REG_ADDR: regRdata <= {12'h0, addr_reg};
                `PNF_REG_WDATA: regRdata <= {16'h0, wdata_reg};
                `PNF_REG_RDATA: regRdata <= {16'h0, rdata_reg};
                `PNF_REG_STAT: regRdata <= {27'h0, tempMode_reg, toggled_reg, readySync, opDone_reg, busy};
                default: regRdata <= '0;
            endcase
        end else begin
            regRdata <= '0;
        end
    end

    // Remembers whether the device may be running an embedded algorithm
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            algoActive_reg <= 1'b0;
        end else if (state_reg == pnf_pkg::PNF_W_HOLD && step_reg == last_step(cmd_reg)
                     && cmd_reg == `PNF_CMD_PROG) begin
            algoActive_reg <= 1'b1;
        end else if (state_reg == pnf_pkg::PNF_RST_REC || (state_reg == pnf_pkg::PNF_IDLE && readySync)) begin
            algoActive_reg <= 1'b0;
        end
    end

    // Long reset recovery is counted here in its own counter, sized from READY_LONG_CYC
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            longCnt_reg <= '0;
        end else if (state_reg == pnf_pkg::PNF_RST_LOW && timerDone) begin
            longCnt_reg <= algoActive_reg ? LONG_W'(READY_LONG_CYC) : '0; // RL3
        end else if (longCnt_reg != '0) begin
            longCnt_reg <= longCnt_reg - LONG_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= pnf_pkg::PNF_IDLE;
            cmd_reg <= '0;
            step_reg <= '0;
            timerLoad <= 1'b0;
            timerVal <= '0;
            flashAddr <= '0;
            flashDqOut <= '0;
            flashDqOe <= 1'b0;
            flashCeN <= 1'b1;
            flashOeN <= 1'b1;
            flashWeN <= 1'b1;
            flashResetN <= 1'b0;
            flashResetHv <= 1'b0;
            flashByteN <= 1'b1;
            rdata_reg <= '0;
            opDone_reg <= 1'b0;
            toggled_reg <= 1'b0;
            lastStat_reg <= '0;
            tempMode_reg <= 1'b0;
        end else begin
            timerLoad <= 1'b0;
            flashByteN <= !byteMode_reg;
            unique case (state_reg)
                pnf_pkg::PNF_IDLE: begin
                    if (startCmd) begin
                        cmd_reg <= regWdata[3:0];
                        step_reg <= '0;
                        opDone_reg <= 1'b0;
                        unique case (regWdata[3:0])
                            `PNF_CMD_RESET: begin
                                flashResetN <= 1'b0;
                                flashCeN <= 1'b1; // RL7
                                timerLoad <= 1'b1;
                                timerVal <= RP_CYC;
                                state_reg <= pnf_pkg::PNF_RST_LOW;
                            end
                            `PNF_CMD_READ, `PNF_CMD_POLL: begin
                                flashAddr <= addr_reg;
                                flashCeN <= 1'b0;
                                flashOeN <= 1'b0; // RL9
                                timerLoad <= 1'b1;
                                timerVal <= READ_CYC;
                                state_reg <= pnf_pkg::PNF_R_PULSE;
                            end
                            `PNF_CMD_TEMPUN: begin
                                flashResetHv <= 1'b1;
                                tempMode_reg <= 1'b1;
                                timerLoad <= 1'b1;
                                timerVal <= RSP_CYC;
                                state_reg <= pnf_pkg::PNF_TEMP_RISE;
                            end
                            `PNF_CMD_PROG, `PNF_CMD_PROT, `PNF_CMD_UNPROT, `PNF_CMD_WRITE: begin
                                timerLoad <= 1'b1;
                                timerVal <= SRW_CYC; // RL10
                                state_reg <= pnf_pkg::PNF_W_SETUP;
                            end
                            default: opDone_reg <= 1'b1;
                        endcase
                    end else if (!flashResetN) begin
                        // Leave the power-up reset low for a full pulse width
                        timerLoad <= 1'b1;
                        timerVal <= RP_CYC;
                        state_reg <= pnf_pkg::PNF_RST_LOW;
                    end
                end
                pnf_pkg::PNF_RST_LOW: begin
                    if (timerDone) begin
                        flashResetN <= 1'b1;
                        timerLoad <= 1'b1;
                        timerVal <= RH_CYC; // RL4 RL5
                        state_reg <= pnf_pkg::PNF_RST_REC;
                    end
                end
                pnf_pkg::PNF_RST_REC: begin
                    if (timerDone && longCnt_reg == '0) begin // RL3 RL5
                        opDone_reg <= 1'b1;
                        state_reg <= pnf_pkg::PNF_IDLE;
                    end
                end
                pnf_pkg::PNF_W_SETUP: begin
                    if (timerDone) begin
                        {flashAddr, flashDqOut} <= write_step(cmd_reg, step_reg, addr_reg, wdata_reg);
                        flashDqOe <= 1'b1;
                        flashCeN <= 1'b0;
                        flashWeN <= 1'b0;
                        timerLoad <= 1'b1;
                        timerVal <= PULSE_CYC;
                        state_reg <= pnf_pkg::PNF_W_PULSE;
                    end
                end
                pnf_pkg::PNF_W_PULSE: begin
                    if (timerDone) begin
                        flashWeN <= 1'b1;
                        flashCeN <= 1'b1;
                        timerLoad <= 1'b1;
                        timerVal <= PULSE_CYC;
                        state_reg <= pnf_pkg::PNF_W_HOLD;
                    end
                end
                pnf_pkg::PNF_W_HOLD: begin
                    if (timerDone) begin
                        flashDqOe <= 1'b0;
                        if (step_reg != last_step(cmd_reg)) begin
                            step_reg <= step_reg + 2'h1;
                            state_reg <= pnf_pkg::PNF_W_SETUP;
                        end else if (cmd_reg == `PNF_CMD_PROG) begin
                            timerLoad <= 1'b1;
                            timerVal <= BUSY_CYC; // RL8
                            state_reg <= pnf_pkg::PNF_BUSY_WAIT;
                        end else begin
                            opDone_reg <= 1'b1;
                            state_reg <= pnf_pkg::PNF_IDLE;
                        end
                    end
                end
                pnf_pkg::PNF_BUSY_WAIT: begin
                    if (timerDone && readySync) begin // RL21 RL9
                        flashAddr <= addr_reg;
                        flashCeN <= 1'b0;
                        flashOeN <= 1'b0;
                        timerLoad <= 1'b1;
                        timerVal <= READ_CYC;
                        cmd_reg <= `PNF_CMD_READ;
                        state_reg <= pnf_pkg::PNF_R_PULSE; // RL2
                    end
                end
                pnf_pkg::PNF_R_PULSE: begin
                    if (timerDone) begin
                        rdata_reg <= dqSync;
                        lastStat_reg <= dqSync;
                        // Toggle detect compares two successive status reads
                        toggled_reg <= (dqSync[`PNF_OPTOG_BIT] != lastStat_reg[`PNF_OPTOG_BIT])
                                       || (dqSync[`PNF_ERTOG_BIT] != lastStat_reg[`PNF_ERTOG_BIT]); // RL11 RL12
                        flashOeN <= 1'b1;
                        flashCeN <= oeStrobe_reg ? 1'b0 : 1'b1; // RL12
                        timerLoad <= 1'b1;
                        timerVal <= SRW_CYC; // RL10
                        state_reg <= pnf_pkg::PNF_R_GAP;
                    end
                end
                pnf_pkg::PNF_R_GAP: begin
                    if (timerDone) begin
                        flashCeN <= 1'b1;
                        opDone_reg <= 1'b1;
                        state_reg <= pnf_pkg::PNF_IDLE;
                    end
                end
                pnf_pkg::PNF_TEMP_RISE: begin
                    if (timerDone) begin // RL15
                        cmd_reg <= `PNF_CMD_WRITE;
                        state_reg <= pnf_pkg::PNF_TEMP_HOLD;
                        opDone_reg <= 1'b1;
                    end
                end
                pnf_pkg::PNF_TEMP_HOLD: begin
                    // No write cycle is issued here; reset stays elevated through the exit command and until PNF_TEMP_OFF ends
                    // Busy is high here, so the exit command is decoded without startCmd
                    if (regWr && regAddr == `PNF_REG_CTRL && regWdata[3:0] == `PNF_CMD_TEMPUN && readySync) begin
                        timerLoad <= 1'b1;
                        timerVal <= RRB_CYC;
                        state_reg <= pnf_pkg::PNF_TEMP_OFF;
                    end
                end
                pnf_pkg::PNF_TEMP_OFF: begin
                    if (!readySync) begin
                        timerLoad <= 1'b1;
                        timerVal <= RRB_CYC; // RL16
                    end else if (timerDone) begin
                        flashResetHv <= 1'b0;
                        tempMode_reg <= 1'b0;
                        opDone_reg <= 1'b1;
                        state_reg <= pnf_pkg::PNF_IDLE;
                    end
                end
                default: state_reg <= pnf_pkg::PNF_IDLE;
            endcase
        end
    end

    a_reset_high_time: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(flashResetN) |-> flashOeN [*5]) // RL5
        else $error("Read started too soon after reset release");

    a_ce_after_reset: assert property (@(posedge clk) disable iff (!rst_b)
        !flashResetN |-> flashCeN) // RL7
        else $error("Chip select low while reset low");

    a_prog_a0_write: assert property (@(posedge clk) disable iff (!rst_b)
        (!flashWeN && cmd_reg == `PNF_CMD_PROG && step_reg == 2'h2) |->
        (flashAddr == `PNF_PROG_ADDR && flashDqOut == `PNF_PROG_DATA)) // RL1
        else $error("Program command write is wrong");

    a_prot_pattern: assert property (@(posedge clk) disable iff (!rst_b)
        (!flashWeN && cmd_reg == `PNF_CMD_PROT) |->
        (flashAddr[`PNF_BIT_A6] == 1'b0 && flashAddr[3:0] == 4'h2)) // RL13
        else $error("Protect address pattern wrong");

    a_unprot_pattern: assert property (@(posedge clk) disable iff (!rst_b)
        (!flashWeN && cmd_reg == `PNF_CMD_UNPROT) |->
        (flashAddr[`PNF_BIT_A6] == 1'b1 && flashAddr[3:0] == 4'h2)) // RL14
        else $error("Unprotect address pattern wrong");

    a_read_write_gap: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(flashOeN) |-> flashWeN [*3]) // RL10
        else $error("Write too close after read");

    a_temp_setup: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(flashResetHv) |-> flashWeN [*8]) // RL15
        else $error("Write during elevated reset setup");

    a_busy_wait: assert property (@(posedge clk) disable iff (!rst_b)
        (state_reg == pnf_pkg::PNF_BUSY_WAIT && !readySync) |=> flashOeN) // RL8
        else $error("Read started while device busy");
endmodule
`default_nettype wire

/* File: dv/pnf_flash_model.sv */
/* Behavioural flash device for the host bench.
   Assumes address and data are settled when a write cycle ends. */
`timescale 1ns/10ps
`default_nettype none
module pnf_flash_model #(
    parameter int PROG_NS = 300
) (
    input wire logic [19:0] addr,
    input wire logic [15:0] dqW,
    input wire logic ceN,
    input wire logic oeN,
    input wire logic weN,
    input wire logic resetN,
    input wire logic byteN,
    output logic [15:0] dq,
    output logic rdyBsyN
);
    logic [15:0] mem [16];
    logic [15:0] pd, q;
    logic [19:0] lastA;
    logic [3:0] pa;
    logic [1:0] step = 0;
    logic busy = 0;
    logic tog = 0;
    wire logic wrEnd = ceN | weN;
    initial foreach (mem[i]) mem[i] = 16'hffff;
    // A write ends at whichever of chip select and write enable rises first
    always @(posedge wrEnd) if (resetN) begin
        lastA = addr;
        if (step == 3) begin
            pa = addr[3:0];
            pd = dqW;
            #50 busy = 1;
        end
        step = (step == 0 && addr[10:0] == 11'h555 && dqW[7:0] == 8'haa) ? 2'h1 :
               (step == 1 && addr[10:0] == 11'h2aa && dqW[7:0] == 8'h55) ? 2'h2 :
               (step == 2 && addr[10:0] == 11'h555 && dqW[7:0] == 8'ha0) ? 2'h3 : 2'h0;
    end
    // Busy for the whole configured duration
    always @(posedge busy) begin
        #PROG_NS;
        if (busy) begin
            mem[pa] = pd;
            busy = 0;
        end
    end
    always @(negedge resetN) begin
        busy = 0;
        step = 0;
    end
    always @(negedge oeN or negedge ceN) if (!oeN && !ceN && busy) tog = ~tog;
    assign rdyBsyN = ~busy;
    // No sector is ever erase-suspended here, so the erase toggle bit stays still
    assign q = busy ? {8'h00, ~pd[7], tog, 6'h00} : mem[addr[3:0]];
    // Released bus shows no stale value
    assign dq = (!ceN && !oeN && resetN) ? {byteN ? q[15:8] : ~q[15:8], q[7:0]} : ~q;
endmodule
`default_nettype wire

/* File: dv/tb_pnf_host.sv */
/* Self-checking bench for the flash host controller.
   Assumes the flash model file and the design files are compiled first. */
`timescale 1ns/10ps
`default_nettype none
`include "pnf_consts.svh"
module tb_pnf_host;
    logic clk = 0, rst_b = 0, regWr = 0, regRd = 0;
    logic flashDqOe, flashCeN, flashOeN, flashWeN, flashResetN, flashByteN, rdyBsyN, hv;
    logic [3:0] regAddr = 0;
    logic [31:0] regWdata = 0, regRdata, s;
    logic [19:0] flashAddr;
    logic [15:0] flashDqOut, flashDqIn;
    int n_errors = 0, samples_checked = 0, cyc = 0;
    typedef struct {logic [19:0] a; logic [15:0] d;} pnf_row_t;
    pnf_row_t rows [3] = '{'{20'h00003, 16'h1234}, '{20'h0000c, 16'h00a5}, '{20'h0000f, 16'hff00}};
    pnf_host #(.READY_LONG_CYC(20)) i_pnf_host (.clk(clk), .rst_b(rst_b), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .flashAddr(flashAddr),
        .flashDqOut(flashDqOut), .flashDqOe(flashDqOe), .flashDqIn(flashDqIn), .flashCeN(flashCeN),
        .flashOeN(flashOeN), .flashWeN(flashWeN), .flashResetN(flashResetN), .flashResetHv(hv),
        .flashByteN(flashByteN), .ready_busy_n(rdyBsyN));
    pnf_flash_model i_pnf_flash_model (.addr(flashAddr), .dqW(flashDqOut), .ceN(flashCeN), .oeN(flashOeN),
        .weN(flashWeN), .resetN(flashResetN), .byteN(flashByteN), .dq(flashDqIn), .rdyBsyN(rdyBsyN));
    initial forever #5 clk = ~clk;
    task automatic report_and_stop;
        if (n_errors == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk) begin regAddr <= a; regWdata <= d; regWr <= 1'b1; end
        @(posedge clk) regWr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk) begin regAddr <= a; regRd <= 1'b1; end
        @(posedge clk) regRd <= 1'b0;
        #1 d = regRdata;
    endtask
    task automatic wait_idle;
        do rd(`PNF_REG_STAT, s); while (s[0] !== 1'b0);
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            n_errors++;
            report_and_stop;
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        chk(32'(flashCeN), 32'h1);
        rst_b <= 1'b1;
        wait_idle;
        foreach (rows[i]) begin
            wr(`PNF_REG_ADDR, 32'(rows[i].a));
            wr(`PNF_REG_WDATA, 32'(rows[i].d));
            wr(`PNF_REG_CTRL, 32'(`PNF_CMD_PROG));
            wait_idle;
            wr(`PNF_REG_CTRL, 32'(i == 1 ? `PNF_CMD_POLL : `PNF_CMD_READ));
            wait_idle;
            rd(`PNF_REG_RDATA, s);
            chk(s, 32'(rows[i].d));
        end
        rd(4'hf, s);
        chk(s, 32'h0);
        wr(`PNF_REG_ADDR, 32'h00540);
        wr(`PNF_REG_CTRL, 32'(`PNF_CMD_PROT));
        wait_idle;
        chk(32'(i_pnf_flash_model.lastA[6:0] & 7'h4f), 32'h02);
        wr(`PNF_REG_CTRL, 32'(`PNF_CMD_UNPROT));
        wait_idle;
        chk(32'(i_pnf_flash_model.lastA[6:0] & 7'h4f), 32'h42);
        wr(`PNF_REG_CTRL, 32'h10 | 32'(`PNF_CMD_READ));
        wait_idle;
        chk(32'(flashByteN), 32'h0);
        wr(`PNF_REG_CTRL, 32'(`PNF_CMD_TEMPUN));
        repeat (410) @(posedge clk);
        rd(`PNF_REG_STAT, s);
        chk(32'({hv, s[4]}), 32'h3);
        wr(`PNF_REG_CTRL, 32'(`PNF_CMD_TEMPUN));
        wait_idle;
        chk(32'(hv), 32'h0);
        wr(`PNF_REG_CTRL, 32'(`PNF_CMD_RESET));
        wait_idle;
        chk(32'(flashResetN), 32'h1);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        wait_idle;
        chk(32'({flashResetN, flashCeN, flashDqOe}), 32'h6);
        report_and_stop;
    end
endmodule
`default_nettype wire
